// file: fpc_checker.sv
// Flash protection checker: error classification, startup area and bank remapping, window.
// Assumes single clock, synchronous inputs and one-cycle command and access pulses.
`include "fpc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module fpc_checker
  import fpc_pkg::*;
#(
  parameter int CODE_FLASH_KB = 2048,
  parameter int BANK_BIT = 20
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic area_access,
  input wire logic area_read,
  input wire logic [2:0] bank_mode_field,
  input wire logic [2:0] startup_bank_swap_field,
  input wire logic [31:0] read_addr,
  output logic [31:0] mapped_addr,
  output logic [31:0] pe_target,
  output logic [9:0] error_flags,
  output logic cmd_locked,
  output logic resume_go
);
  localparam logic [3:0] BOOT_RESET_BITS = `FPC_BOOT_RESET;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] mode_reg;
  logic self_prog_reg;
  logic [1:0] write_enable_protect_register;
  logic [31:0] command_start_address;
  logic [10:0] win_start_reg;
  logic [10:0] win_end_reg;
  logic window_protect_bit;
  logic startup_select_flag;
  logic [1:0] startup_area_select_field;
  logic [2:0] bank_mode_reg;
  logic [2:0] bank_swap_reg;
  logic opt_taken_reg;
  fpc_flags_t flags_reg;
  fpc_flags_t flags_set;
  logic erase_suspended_flag;
  logic program_suspended_flag;
  logic resumable_reg;
  logic last_erase_reg;
  logic clear_req;
  logic stop_req;
  logic dual_ok;
  logic dual_mode;
  logic su_swap;
  logic bank_swap;
  logic pe_cmd;
  logic df_hit;
  logic [10:0] blk;
  logic in_window;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Option memory is sampled once, on the first edge after reset release.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_mode_reg <= 3'h7;
      bank_swap_reg <= `FPC_SWAP_NONE;
      opt_taken_reg <= 1'b0;
    end else if (!opt_taken_reg) begin
      bank_mode_reg <= bank_mode_field; // RULE15
      bank_swap_reg <= startup_bank_swap_field; // RULE16
      opt_taken_reg <= 1'b1;
    end
  end

  assign dual_ok = (CODE_FLASH_KB >= `FPC_DUAL_MIN_KB); // RULE17
  assign dual_mode = dual_ok && (bank_mode_reg == `FPC_BANK_DUAL); // RULE15
  assign bank_swap = dual_mode && (bank_swap_reg != `FPC_SWAP_NONE); // RULE16
  // Startup swap: select 0x swaps while the flag is zero, 1x forces the swap by bit 0.
  assign su_swap = !dual_mode && // RULE10
    (startup_area_select_field[1] ? startup_area_select_field[0] : !startup_select_flag); // RULE8

  function automatic logic [31:0] remap(input logic [31:0] a);
    logic [31:0] r;
    r = a;
    if (su_swap && (a >= `FPC_SU_LO)) begin
      r[`FPC_SU_BIT] = ~a[`FPC_SU_BIT]; // RULE11
    end
    if (bank_swap && (a[31:24] == `FPC_USER_TOP)) begin
      r[BANK_BIT] = ~a[BANK_BIT];
    end
    return r;
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mapped_addr <= 32'h0;
      pe_target <= 32'h0;
    end else begin
      mapped_addr <= remap(read_addr); // RULE12
      pe_target <= remap(command_start_address); // RULE12
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 2'h0;
      self_prog_reg <= 1'b1;
      write_enable_protect_register <= 2'h0;
      command_start_address <= 32'h0;
      win_start_reg <= 11'h0;
      win_end_reg <= 11'h7ff;
    end else if (wr_en) begin
      case (addr)
        `FPC_OFS_CTRL: begin
          mode_reg <= wdata[1:0];
          self_prog_reg <= wdata[2];
        end
        `FPC_OFS_WEPROT: write_enable_protect_register <= wdata[1:0];
        `FPC_OFS_SADDR: command_start_address <= wdata;
        `FPC_OFS_WINDOW: begin
          win_start_reg <= wdata[10:0];
          win_end_reg <= wdata[26:16];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      window_protect_bit <= BOOT_RESET_BITS[0];
      startup_select_flag <= BOOT_RESET_BITS[1];
      startup_area_select_field <= BOOT_RESET_BITS[3:2];
    end else if (wr_en && (addr == `FPC_OFS_BOOT)) begin
      window_protect_bit <= window_protect_bit & wdata[0]; // RULE9
      if (window_protect_bit) begin
        startup_select_flag <= wdata[1]; // RULE9
        startup_area_select_field <= wdata[3:2];
      end
    end
  end

  assign pe_cmd = (cmd_code == 4'(FPC_CMD_PROGRAM)) || (cmd_code == 4'(FPC_CMD_BLOCK_ERASE))
    || (cmd_code == 4'(FPC_CMD_MULTI_ERASE));
  assign df_hit = (command_start_address[16:0] >= `FPC_DF_LO)
    && (command_start_address[16:0] <= `FPC_DF_HI);
  assign blk = command_start_address[23:13];
  assign in_window = (blk >= win_start_reg) && (blk < win_end_reg);

  always_comb begin
    flags_set = '0;
    if (cmd_valid) begin
      if (pe_cmd && (write_enable_protect_register != `FPC_WE_ENABLE)) begin
        flags_set[7] = 1'b1; // RULE6
        flags_set[5] = (cmd_code != 4'(FPC_CMD_PROGRAM)); // RULE6
        flags_set[6] = (cmd_code == 4'(FPC_CMD_PROGRAM)); // RULE6
      end else if ((mode_reg == 2'(FPC_MODE_DATA_PE)) && df_hit
          && (cmd_code <= 4'(FPC_CMD_BLANK_CHECK))) begin
        if ((cmd_code == 4'(FPC_CMD_PROGRAM)) || (cmd_code == 4'(FPC_CMD_BLOCK_ERASE))) begin
          flags_set[4] = 1'b1; // RULE1
          flags_set[9] = 1'b1; // RULE7
        end else if ((cmd_code == 4'(FPC_CMD_MULTI_ERASE))
            || (cmd_code == 4'(FPC_CMD_BLANK_CHECK))) begin
          flags_set[0] = 1'b1; // RULE2
          flags_set[4] = 1'b1; // RULE2
          flags_set[9] = 1'b1; // RULE7
        end
      end else if ((cmd_code == 4'(FPC_CMD_CONFIG_SET)) && !window_protect_bit
          && ((command_start_address[9:0] & `FPC_CFG_WIN_MASK) == `FPC_CFG_WIN_ADDR)) begin
        flags_set[2] = 1'b1; // RULE3
        flags_set[4] = 1'b1; // RULE3
      end else if (pe_cmd && (mode_reg == 2'(FPC_MODE_CODE_PE)) && self_prog_reg
          && (command_start_address[31:24] == `FPC_USER_TOP) && !in_window) begin
        flags_set[4] = 1'b1; // RULE13 RULE14
      end
    end
    if (area_access) begin
      if (mode_reg == 2'(FPC_MODE_READ)) begin
        flags_set[3] = 1'b1; // RULE4
        flags_set[4] = 1'b1; // RULE4
      end else if (area_read) begin
        flags_set[3] = 1'b1; // RULE5
        flags_set[4] = 1'b1; // RULE5
      end
    end
  end

  assign stop_req = cmd_valid && (cmd_code == 4'(FPC_CMD_FORCED_STOP));
  assign clear_req = stop_req || (cmd_valid && (cmd_code == 4'(FPC_CMD_STATUS_CLEAR)))
    || (wr_en && (addr == `FPC_OFS_CLEAR) && wdata[0]);

  // A new error in the clearing cycle survives the clear.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (clear_req ? '0 : flags_reg) | flags_set; // RULE21
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_erase_reg <= 1'b0;
      erase_suspended_flag <= 1'b0;
      program_suspended_flag <= 1'b0;
      resumable_reg <= 1'b0;
      resume_go <= 1'b0;
    end else begin
      resume_go <= 1'b0;
      if (cmd_valid && pe_cmd && (flags_set == '0)) begin
        last_erase_reg <= (cmd_code != 4'(FPC_CMD_PROGRAM));
      end
      if (cmd_valid && (cmd_code == 4'(FPC_CMD_SUSPEND))) begin
        erase_suspended_flag <= last_erase_reg;
        program_suspended_flag <= !last_erase_reg;
        resumable_reg <= 1'b1;
      end else if (cmd_valid && (cmd_code == 4'(FPC_CMD_RESUME))) begin
        resume_go <= resumable_reg; // RULE18
        erase_suspended_flag <= 1'b0;
        program_suspended_flag <= 1'b0;
        resumable_reg <= 1'b0;
      end else if (stop_req && flags_reg[4]) begin
        resumable_reg <= 1'b0; // RULE18
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      error_flags <= '0;
      cmd_locked <= 1'b0;
    end else begin
      error_flags <= (clear_req ? '0 : flags_reg) | flags_set;
      cmd_locked <= ((clear_req ? 1'b0 : flags_reg[4]) | flags_set[4]); // RULE13
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd_en) begin
      case (addr)
        `FPC_OFS_CTRL: rdata <= {29'h0, self_prog_reg, mode_reg};
        `FPC_OFS_WEPROT: rdata <= {30'h0, write_enable_protect_register};
        `FPC_OFS_STATUS: rdata <= {19'h0, resumable_reg, program_suspended_flag,
          erase_suspended_flag, flags_reg};
        `FPC_OFS_SADDR: rdata <= command_start_address;
        `FPC_OFS_WINDOW: rdata <= {5'h0, win_end_reg, 5'h0, win_start_reg};
        `FPC_OFS_BOOT: rdata <= {28'h0, startup_area_select_field, startup_select_flag,
          window_protect_bit};
        `FPC_OFS_OPTION: rdata <= {24'h0, 1'b0, dual_mode, bank_swap, su_swap, 1'b0,
          bank_mode_reg};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// file: fpc_regs.svh
// Register offsets, field positions, reset values and address constants of the flash checker.
// Assumes inclusion from the checker module, its bound assertions and the test bench.
// Notes on behaviour
// RULE1: Data P/E program or block erase in 0 8000h..1 FFFFh sets lock and data-violation.
// RULE2: Data P/E multi-erase or blank check there sets illegal-command, lock, data-violation.
// RULE3: Window protect clear: config set of window or startup flag sets security and lock.
// RULE4: Command area access in read mode sets only other-error and lock.
// RULE5: Command area read in code or data P/E mode sets other-error and lock.
// RULE6: Write-enable protect off: write-enable error plus erase/program error, never lock.
// RULE7: Start address meeting the data-violation condition sets the data-violation status bit.
// RULE8: An 8 KB startup area, chosen by startup flag and area select field.
// RULE9: Window protect never returns to one; while zero startup selection is frozen.
// RULE10: Startup protection unavailable when bank mode is dual, value 000b.
// RULE11: Flag one, select 0x: C000h-DFFFh is area 1, E000h-FFFFh is area 0.
// RULE12: Swap applies to read, program and erase; swapped erase at C000h hits area 0.
// RULE13: Program or erase outside the access window locks the sequencer.
// RULE14: Window checked only in code user area, self/serial mode, per block.
// RULE15: Bank mode taken at reset; 000b is dual with startup bank selection.
// RULE16: Dual mode swap field exchanges banks 0 and 1 for reads and commands.
// RULE17: Dual bank exists only with at least 1.5 MB of code flash.
// RULE18: Resume restarts suspended work unless lock then forced stop followed the suspend.
// RULE19: Host erases an area before programming it again; option memory excepted.
// RULE20: Host avoids reading areas left by forced stop or suspension.
// RULE21: Error flags and lock stay until status clear or forced stop.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_OFS_CTRL 8'h00
`define FPC_OFS_WEPROT 8'h04
`define FPC_OFS_STATUS 8'h08
`define FPC_OFS_CLEAR 8'h0c
`define FPC_OFS_SADDR 8'h10
`define FPC_OFS_WINDOW 8'h14
`define FPC_OFS_BOOT 8'h18
`define FPC_OFS_OPTION 8'h1c
`define FPC_WE_ENABLE 2'h1
`define FPC_BOOT_RESET 4'h3
`define FPC_DF_LO 17'h08000
`define FPC_DF_HI 17'h1ffff
`define FPC_USER_TOP 8'hff
`define FPC_SU_LO 32'hffffc000
`define FPC_SU_BIT 13
`define FPC_CFG_WIN_ADDR 10'h100
`define FPC_CFG_WIN_MASK 10'h3f0
`define FPC_BANK_DUAL 3'h0
`define FPC_SWAP_NONE 3'h7
`define FPC_DUAL_MIN_KB 1536
`endif

// file: fpc_pkg.sv
// Types shared by the flash checker.
// Assumes fpc_regs.svh holds the numeric constants.
`default_nettype none
package fpc_pkg;
  typedef enum {FPC_MODE_READ, FPC_MODE_CODE_PE, FPC_MODE_DATA_PE, FPC_MODE_RSVD} fpc_mode_e;
  typedef enum {
    FPC_CMD_PROGRAM, FPC_CMD_BLOCK_ERASE, FPC_CMD_MULTI_ERASE, FPC_CMD_BLANK_CHECK,
    FPC_CMD_CONFIG_SET, FPC_CMD_SUSPEND, FPC_CMD_RESUME, FPC_CMD_STATUS_CLEAR, FPC_CMD_FORCED_STOP
  } fpc_cmd_e;
  typedef logic [9:0] fpc_flags_t;
endpackage
`default_nettype wire

// file: fpc_watch_checker.sv
// Assertions on the ports of the flash protection checker.
// Assumes one clock and the offsets of fpc_regs.svh.
`include "fpc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module fpc_watch (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic area_access,
  input wire logic area_read,
  input wire logic [9:0] error_flags,
  input wire logic cmd_locked
);
  logic [1:0] mode_reg;
  logic [1:0] we_reg;
  logic [31:0] sa_reg;
  logic prot_reg;
  logic clr;
  logic pe_ok;
  logic df_hit;
  // Shadows of the registers that steer the classification.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= 2'h0;
      we_reg <= 2'h0;
      sa_reg <= 32'h0;
      prot_reg <= 1'b1;
    end else if (wr_en) begin
      if (addr == `FPC_OFS_CTRL) mode_reg <= wdata[1:0];
      if (addr == `FPC_OFS_WEPROT) we_reg <= wdata[1:0];
      if (addr == `FPC_OFS_SADDR) sa_reg <= wdata;
      if (addr == `FPC_OFS_BOOT) prot_reg <= prot_reg & wdata[0];
    end
  end
  assign pe_ok = we_reg == `FPC_WE_ENABLE;
  assign df_hit = mode_reg == 2'h2 && pe_ok && sa_reg[16:0] >= `FPC_DF_LO;
  assign clr = (wr_en && addr == `FPC_OFS_CLEAR && wdata[0]) || (cmd_valid && cmd_code >= 4'h7);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  lock_level_a: assert property (cmd_locked == error_flags[4])
    else $error("lock output differs from lock flag");
  area_idle_a: assert property (area_access && mode_reg == 2'h0 && !cmd_valid && !clr
    |=> error_flags[4:3] == 2'h3) else $error("area access in read mode not flagged");
  area_read_a: assert property (area_access && area_read && mode_reg != 2'h0 && !clr
    |=> error_flags[4:3] == 2'h3) else $error("area read in program mode not flagged");
  write_enable_a: assert property (cmd_valid && cmd_code < 4'h3 && !pe_ok
    |=> error_flags[7] && error_flags[4] == $past(error_flags[4])) else $error("write enable");
  df_one_a: assert property (cmd_valid && cmd_code < 4'h2 && df_hit
    |=> error_flags[9] && error_flags[4]) else $error("data violation not flagged");
  df_multi_a: assert property (cmd_valid && cmd_code inside {4'h2, 4'h3} && df_hit
    |=> error_flags[0] && error_flags[4] && error_flags[9]) else $error("multi violation");
  sec_a: assert property (cmd_valid && cmd_code == 4'h4 && pe_ok && !prot_reg
    && (sa_reg[9:0] & `FPC_CFG_WIN_MASK) == `FPC_CFG_WIN_ADDR |=> error_flags[2] && error_flags[4])
    else $error("security error not flagged");
  flag_hold_a: assert property (error_flags[4] && !clr |=> error_flags[4])
    else $error("lock flag dropped without clear");
endmodule
bind fpc_checker fpc_watch u_watch (.clock(clock), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .area_access(area_access), .area_read(area_read), .error_flags(error_flags),
  .cmd_locked(cmd_locked));
`default_nettype wire

// file: flash_protection_checker_test.sv
// Self-checking bench driving the register port, command and area pulses.
// Assumes fpc_checker and its bound assertions are compiled first.
`include "fpc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module flash_protection_checker_test;
  logic clock;
  logic resetn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic area_access;
  logic area_read;
  logic [31:0] read_addr;
  logic [31:0] mapped_addr;
  logic [31:0] pe_target;
  logic [9:0] error_flags;
  logic cmd_locked;
  logic resume_go;
  logic [2:0] bank_mode;
  logic [2:0] swap_sel;
  logic [9:0] ign;
  int fail_count;
  int tests_run;
  fpc_checker u_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .area_access(area_access), .area_read(area_read), .bank_mode_field(bank_mode),
    .startup_bank_swap_field(swap_sel), .read_addr(read_addr), .mapped_addr(mapped_addr),
    .pe_target(pe_target), .error_flags(error_flags), .cmd_locked(cmd_locked),
    .resume_go(resume_go));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Kind 0 issues a command; kind 2 or 3 touches the command area, 3 as a read.
  task automatic act(input logic [1:0] k, input logic [3:0] c, input logic [9:0] e);
    @(posedge clock);
    cmd_code <= c;
    cmd_valid <= k == 2'h0;
    area_access <= k[1];
    area_read <= k[0];
    @(posedge clock);
    cmd_valid <= 1'b0;
    area_access <= 1'b0;
    #1 chk({22'h0, error_flags & ~ign}, {22'h0, e});
    chk({31'h0, cmd_locked}, {31'h0, e[4]});
  endtask
  task automatic map(input logic [31:0] ra, input logic [31:0] e);
    @(posedge clock);
    read_addr <= ra;
    @(posedge clock);
    #1 chk(mapped_addr, e);
  endtask
  initial begin
    resetn = 1'b0;
    {addr, wdata, wr_en, rd_en, cmd_valid, cmd_code} = '0;
    {area_access, area_read, read_addr, ign} = '0;
    bank_mode = 3'h7;
    swap_sel = `FPC_SWAP_NONE;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`FPC_OFS_STATUS, 32'h0);
    rd(`FPC_OFS_WINDOW, 32'h07ff0000);
    rd(`FPC_OFS_BOOT, 32'h3);
    rd(8'h40, 32'h0);
    rd(`FPC_OFS_OPTION, 32'h7);
    map(32'hffffc000, 32'hffffc000);
    map(32'hffffe000, 32'hffffe000);
    wr(`FPC_OFS_BOOT, 32'h1);
    map(32'hffffc000, 32'hffffe000);
    map(32'hffffe010, 32'hffffc010);
    wr(`FPC_OFS_SADDR, 32'hffffc000);
    @(posedge clock);
    #1 chk(pe_target, 32'hffffe000);
    wr(`FPC_OFS_BOOT, 32'h3);
    act(2'h2, 4'h0, 10'h018);
    repeat (3) @(posedge clock);
    #1 chk({22'h0, error_flags}, 32'h18);
    wr(`FPC_OFS_CLEAR, 32'h1);
    @(posedge clock);
    #1 chk({22'h0, error_flags}, 32'h0);
    wr(`FPC_OFS_CTRL, 32'h6);
    act(2'h3, 4'h0, 10'h018);
    act(2'h0, 4'h7, 10'h000);
    wr(`FPC_OFS_WEPROT, 32'h0);
    ign = 10'h060;
    act(2'h0, 4'h0, 10'h080);
    ign = 10'h0;
    wr(`FPC_OFS_WEPROT, 32'h1);
    act(2'h0, 4'h7, 10'h000);
    for (int i = 0; i < 8; i++) begin
      wr(`FPC_OFS_SADDR, i[0] ? 32'h0001ffff : 32'h00008000);
      act(2'h0, {2'h0, i[2:1]}, i[2] ? 10'h211 : 10'h210);
      rd(`FPC_OFS_STATUS, i[2] ? 32'h211 : 32'h210);
      act(2'h0, 4'h7, 10'h000);
    end
    wr(`FPC_OFS_SADDR, 32'h00007fff);
    act(2'h0, 4'h0, 10'h000);
    wr(`FPC_OFS_CTRL, 32'h5);
    wr(`FPC_OFS_WINDOW, 32'h00070004);
    wr(`FPC_OFS_SADDR, 32'hff00e000);
    act(2'h0, 4'h0, 10'h010);
    act(2'h0, 4'h8, 10'h000);
    wr(`FPC_OFS_CTRL, 32'h1);
    act(2'h0, 4'h0, 10'h000);
    wr(`FPC_OFS_CTRL, 32'h5);
    wr(`FPC_OFS_SADDR, 32'hff008000);
    act(2'h0, 4'h1, 10'h000);
    wr(`FPC_OFS_BOOT, 32'h2);
    rd(`FPC_OFS_BOOT, 32'h2);
    wr(`FPC_OFS_BOOT, 32'hf);
    rd(`FPC_OFS_BOOT, 32'h2);
    wr(`FPC_OFS_SADDR, 32'h00000100);
    act(2'h0, 4'h4, 10'h014);
    act(2'h0, 4'h7, 10'h000);
    wr(`FPC_OFS_CTRL, 32'h6);
    wr(`FPC_OFS_SADDR, 32'h00008100);
    act(2'h0, 4'h4, 10'h014);
    act(2'h0, 4'h7, 10'h000);
    act(2'h0, 4'h5, 10'h000);
    rd(`FPC_OFS_STATUS, 32'h1400);
    act(2'h0, 4'h6, 10'h000);
    chk({31'h0, resume_go}, 32'h1);
    act(2'h0, 4'h5, 10'h000);
    act(2'h3, 4'h0, 10'h018);
    act(2'h0, 4'h8, 10'h000);
    act(2'h0, 4'h6, 10'h000);
    chk({31'h0, resume_go}, 32'h0);
    // Second reset brings up dual mode with the bank swap selected.
    @(posedge clock);
    resetn <= 1'b0;
    bank_mode <= `FPC_BANK_DUAL;
    swap_sel <= 3'h0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`FPC_OFS_STATUS, 32'h0);
    rd(`FPC_OFS_OPTION, 32'h60);
    map(32'hff000000, 32'hff100000);
    wr(`FPC_OFS_BOOT, 32'h1);
    map(32'hffffc000, 32'hffefc000);
    report_and_stop();
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
